// File: bridge_window_upper_config_regs.sv
// Purpose: Upper halves of the prefetchable and I/O forwarding windows, the
//          capability pointer and the interrupt pin field, plus the window check.
// Assumes: Lower base/limit fields arrive as inputs from the neighbouring bank.
// Notes:   Overview of operation below; read data is registered one cycle later.
//          Writes take effect at the next edge and give no response.
//          The forward check answers one cycle after each request.
//          Dword map: 0x28 upper prefetch base, 0x2c upper prefetch limit,
//          0x30 upper I/O base in bytes 0-1 and upper I/O limit in bytes 2-3,
//          0x34 capability pointer, 0x3c interrupt pin field in byte 1.
//          Every other offset reads zero without a hit and ignores writes.
`timescale 1ns/1ps
module bridge_window_upper_config_regs (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Configuration cycles from the primary bus and their read answers.
  input  wire bridge_window_pkg::cfg_req_t cfg_req,
  output      bridge_window_pkg::cfg_rsp_t cfg_rsp,
  // Lower window bits held by the neighbouring bank.
  input  wire logic [11:0]                 prefetch_base_low,
  input  wire logic [11:0]                 prefetch_limit_low,
  input  wire logic [3:0]                  io_base_low,
  input  wire logic [3:0]                  io_limit_low,
  output      logic [3:0]                  prefetch_addr64_ind,
  // Transaction address to be checked against the windows.
  input  wire bridge_window_pkg::fwd_req_t fwd_req,
  output      logic                        fwd_hit,
  // Register contents for the forwarding decode outside this bank.
  output      logic [31:0]                 prefetch_base_high,
  output      logic [31:0]                 prefetch_limit_high,
  output      logic [15:0]                 io_base_high,
  output      logic [15:0]                 io_limit_high
);

  logic [31:0]                 pf_base_q,  pf_base_d;
  logic [31:0]                 pf_limit_q, pf_limit_d;
  logic [15:0]                 io_base_q,  io_base_d;
  logic [15:0]                 io_limit_q, io_limit_d;
  bridge_window_pkg::cfg_rsp_t rsp_q,      rsp_d;
  logic                        hit_q,      hit_d;
  logic                        wr;
  logic                        rd;
  logic                        sel_pf_base;
  logic                        sel_pf_limit;
  logic                        sel_io;
  logic                        pf_lo_ok, pf_hi_ok;
  logic                        io_lo_ok, io_hi_ok;
  logic                        io_upper_zero;
  logic [31:0]                 lane_mask;
  logic [63:0]                 pf_lo_addr, pf_hi_addr;
  logic [31:0]                 io_lo_addr, io_hi_addr;

  // A request is taken on any edge at which valid is high, one per cycle.
  assign wr = cfg_req.valid && cfg_req.write;
  assign rd = cfg_req.valid && !cfg_req.write;

  // Offset decode for the write path; reads decode in their own case below.
  assign sel_pf_base  = (cfg_req.offset == bridge_window_pkg::OFS_PREFETCH_BASE_HIGH);
  assign sel_pf_limit = (cfg_req.offset == bridge_window_pkg::OFS_PREFETCH_LIMIT_HIGH);
  assign sel_io       = (cfg_req.offset == bridge_window_pkg::OFS_IO_HIGH);

  // Byte lane enables are active low; a cleared lane bit means the byte is written.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{~cfg_req.primary_command_byte_lanes[gi]}};
    end
  endgenerate

  always_comb begin
    pf_base_d  = pf_base_q;
    pf_limit_d = pf_limit_q;
    io_base_d  = io_base_q;
    io_limit_d = io_limit_q;
    // Each enabled lane replaces one byte; disabled lanes keep the old byte.
    if (wr && sel_pf_base) begin
      pf_base_d = (pf_base_q & ~lane_mask) | (cfg_req.wdata & lane_mask);
    end
    if (wr && sel_pf_limit) begin
      pf_limit_d = (pf_limit_q & ~lane_mask) | (cfg_req.wdata & lane_mask);
    end
    // Both halves of the I/O dword change together when all lanes are on.
    if (wr && sel_io) begin
      io_base_d  = (io_base_q & ~lane_mask[15:0])
                 | (cfg_req.wdata[15:0] & lane_mask[15:0]);
      io_limit_d = (io_limit_q & ~lane_mask[31:16])
                 | (cfg_req.wdata[31:16] & lane_mask[31:16]);
    end
  end

  // Reads of the capability and interrupt dwords only return constants, so
  // writes there fall through the decode above and change nothing.
  always_comb begin
    rsp_d = '0;
    if (rd) begin
      rsp_d.hit = 1'b1;
      unique case (cfg_req.offset)
        bridge_window_pkg::OFS_PREFETCH_BASE_HIGH:  rsp_d.rdata = pf_base_q;
        bridge_window_pkg::OFS_PREFETCH_LIMIT_HIGH: rsp_d.rdata = pf_limit_q;
        bridge_window_pkg::OFS_IO_HIGH:             rsp_d.rdata = {io_limit_q, io_base_q};
        bridge_window_pkg::OFS_CAPABILITY: begin
          rsp_d.rdata = {24'h00_0000, bridge_window_pkg::CAPABILITY_LIST_OFFSET};
        end
        bridge_window_pkg::OFS_INTERRUPT: begin
          rsp_d.rdata = {16'h0000, bridge_window_pkg::INTERRUPT_PIN_VALUE, 8'h00};
        end
        default: rsp_d.hit = 1'b0;
      endcase
    end
  end

  // Assembled windows: base pads with zeros, limit pads with ones.
  // No enable qualifies the hit here; until software has written the bases
  // and limits the reset values describe no usable window, so the decode
  // outside this bank must not act on the hit before then.
  // The bridge may read ahead anywhere inside the prefetchable window, so it
  // must only cover targets whose reads have no side effects.
  always_comb begin
    pf_lo_addr = {pf_base_q, prefetch_base_low,
                  {bridge_window_pkg::PREFETCH_GRAIN_BITS{1'b0}}};
    pf_hi_addr = {pf_limit_q, prefetch_limit_low,
                  {bridge_window_pkg::PREFETCH_GRAIN_BITS{1'b1}}};
    io_lo_addr = {io_base_q, io_base_low,
                  {bridge_window_pkg::IO_GRAIN_BITS{1'b0}}};
    io_hi_addr = {io_limit_q, io_limit_low,
                  {bridge_window_pkg::IO_GRAIN_BITS{1'b1}}};
    // An I/O address must have its upper 32 bits clear to match at all.
    io_upper_zero = (fwd_req.addr[63:32] == 32'h0000_0000);
    io_lo_ok      = (fwd_req.addr[31:0] >= io_lo_addr);
    io_hi_ok      = (fwd_req.addr[31:0] <= io_hi_addr);
    pf_lo_ok      = (fwd_req.addr >= pf_lo_addr);
    pf_hi_ok      = (fwd_req.addr <= pf_hi_addr);
    hit_d = 1'b0;
    if (fwd_req.valid) begin
      if (fwd_req.is_io) begin
        hit_d = io_upper_zero && io_lo_ok && io_hi_ok;
      end else begin
        hit_d = pf_lo_ok && pf_hi_ok;
      end
    end
  end

  // Configuration registers; a read in the cycle after a write sees the new value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pf_base_q  <= bridge_window_pkg::RST_PREFETCH_BASE_HIGH;
      pf_limit_q <= bridge_window_pkg::RST_PREFETCH_LIMIT_HIGH;
      io_base_q  <= bridge_window_pkg::RST_IO_BASE_HIGH;
      io_limit_q <= bridge_window_pkg::RST_IO_LIMIT_HIGH;
    end else begin
      pf_base_q  <= pf_base_d;
      pf_limit_q <= pf_limit_d;
      io_base_q  <= io_base_d;
      io_limit_q <= io_limit_d;
    end
  end

  // Read response, recomputed every cycle so it stands for one cycle only.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // Forward check result, one cycle after each request.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  // The 64-bit flag belongs to the lower prefetch registers and is exported.
  assign prefetch_addr64_ind = bridge_window_pkg::ADDR64_INDICATOR;
  assign cfg_rsp             = rsp_q;
  assign fwd_hit             = hit_q;
  assign prefetch_base_high  = pf_base_q;
  assign prefetch_limit_high = pf_limit_q;
  assign io_base_high        = io_base_q;
  assign io_limit_high       = io_limit_q;

endmodule : bridge_window_upper_config_regs

// File: bridge_window_pkg.sv
// Purpose: Shared constants and carriers for the bridge upper window registers.
// Assumes: Dword-aligned configuration offsets, active-low byte lanes.
// Notes:   Byte lane enables are active low, one per byte of the dword.
package bridge_window_pkg;

  localparam logic [7:0]  OFS_PREFETCH_BASE_HIGH  = 8'h28;
  localparam logic [7:0]  OFS_PREFETCH_LIMIT_HIGH = 8'h2c;
  localparam logic [7:0]  OFS_IO_HIGH             = 8'h30;
  localparam logic [7:0]  OFS_CAPABILITY          = 8'h34;
  localparam logic [7:0]  OFS_INTERRUPT           = 8'h3c;

  localparam logic [31:0] RST_PREFETCH_BASE_HIGH  = 32'h0000_0000;
  localparam logic [31:0] RST_PREFETCH_LIMIT_HIGH = 32'h0000_0000;
  localparam logic [15:0] RST_IO_BASE_HIGH        = 16'h0000;
  localparam logic [15:0] RST_IO_LIMIT_HIGH       = 16'h0000;
  localparam logic [7:0]  CAPABILITY_LIST_OFFSET  = 8'hdc;
  localparam logic [7:0]  INTERRUPT_PIN_VALUE     = 8'h00;

  localparam int          PREFETCH_GRAIN_BITS     = 20;
  localparam int          IO_GRAIN_BITS           = 12;
  localparam logic [3:0]  ADDR64_INDICATOR        = 4'h1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  offset;
    logic [3:0]  primary_command_byte_lanes;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        hit;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic [63:0] addr;
    logic        is_io;
    logic        valid;
  } fwd_req_t;

endpackage : bridge_window_pkg

// File: bwu_chk_sva.sv
// Purpose: Port checks for the upper window register bank.
// Assumes: One clock; rst is asynchronous and active high.
// Notes:   Attached to every bank instance by bind.
`timescale 1ns/1ps
module bwu_chk (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire bridge_window_pkg::cfg_req_t cfg_req,
  input wire bridge_window_pkg::cfg_rsp_t cfg_rsp,
  input wire logic [3:0]                  prefetch_addr64_ind,
  input wire logic [31:0]                 prefetch_base_high,
  input wire logic [31:0]                 prefetch_limit_high,
  input wire logic [15:0]                 io_base_high,
  input wire logic [15:0]                 io_limit_high
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic       rd = cfg_req.valid && !cfg_req.write;
  wire logic       wr = cfg_req.valid && cfg_req.write;
  wire logic [3:0] ln = cfg_req.primary_command_byte_lanes;
  AST_PB: assert property (wr && ln == 4'h0 && cfg_req.offset == 8'h28 |=>
    prefetch_base_high == $past(cfg_req.wdata)) else $error("base write lost");
  AST_PL: assert property (wr && ln == 4'h0 && cfg_req.offset == 8'h2c |=>
    prefetch_limit_high == $past(cfg_req.wdata)) else $error("limit write lost");
  AST_IB: assert property (wr && ln[1:0] == 2'h0 && cfg_req.offset == 8'h30 |=>
    io_base_high == $past(cfg_req.wdata[15:0])) else $error("io base write lost");
  AST_IL: assert property (wr && ln[3:2] == 2'h3 && cfg_req.offset == 8'h30 |=>
    $stable(io_limit_high)) else $error("io limit changed");
  AST_RD: assert property (rd && cfg_req.offset == 8'h2c |=>
    cfg_rsp.hit && cfg_rsp.rdata == prefetch_limit_high) else $error("limit read wrong");
  AST_CAP: assert property (rd && cfg_req.offset == 8'h34 |=>
    cfg_rsp == 33'h1_0000_00dc) else $error("capability dword wrong");
  AST_INT: assert property (rd && cfg_req.offset == 8'h3c |=>
    cfg_rsp == 33'h1_0000_0000) else $error("interrupt dword wrong");
  AST_IND: assert property (prefetch_addr64_ind == 4'h1) else $error("64-bit flag wrong");
endmodule : bwu_chk
bind bridge_window_upper_config_regs bwu_chk bwu_chk_inst (.*);

// File: cfg_sw_model.sv
// Purpose: Configuration software issuing one cycle at a time.
// Assumes: Requests launch just after a rising edge.
// Notes:   Idle data is inverted so stale values never look valid.
`timescale 1ns/1ps
module cfg_sw_model (
  input  wire logic                        core_clk,
  output      bridge_window_pkg::cfg_req_t cfg_req
);
  initial cfg_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] n,
                      input logic [31:0] d);
    @(posedge core_clk);
    cfg_req <= {1'b1, w, a, n, d};
    @(posedge core_clk);
    cfg_req <= {2'b00, a, 4'hf, ~d};
  endtask : xfer
endmodule : cfg_sw_model

// File: testbench.sv
// Purpose: Self-checking bench for the upper window register bank.
// Assumes: The software model drives all configuration cycles.
// Notes:   Expected results wait in queues until the outputs answer.
`timescale 1ns/1ps
module testbench;
  logic                        core_clk, rst, fwd_hit, v;
  bridge_window_pkg::cfg_req_t cfg_req;
  bridge_window_pkg::cfg_rsp_t cfg_rsp;
  bridge_window_pkg::fwd_req_t fwd_req;
  logic [11:0]                 pbl, pll;
  logic [3:0]                  ibl, ill;
  logic [31:0]                 r, ev [5], wd [6];
  logic [63:0]                 lo, hi;
  logic [32:0]                 rq [$];
  logic                        fq [$];
  int                          fail_count, n_checks;
  logic [7:0]                  ofs [5] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c};
  logic [7:0]                  wo [6] = '{8'h28, 8'h2c, 8'h30, 8'h30, 8'h34, 8'h3c};
  logic [3:0]                  wl [6] = '{4'h0, 4'h0, 4'hc, 4'h3, 4'h0, 4'h0};
  bridge_window_upper_config_regs bridge_window_upper_config_regs_inst (.core_clk(core_clk),
    .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .prefetch_base_low(pbl),
    .prefetch_limit_low(pll), .io_base_low(ibl), .io_limit_low(ill), .prefetch_addr64_ind(),
    .fwd_req(fwd_req), .fwd_hit(fwd_hit), .prefetch_base_high(), .prefetch_limit_high(),
    .io_base_high(), .io_limit_high());
  cfg_sw_model cfg_sw_model_inst (.core_clk(core_clk), .cfg_req(cfg_req));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_all();
    foreach (ofs[i]) begin
      rq.push_back({1'b1, ev[i]});
      cfg_sw_model_inst.xfer(1'b0, ofs[i], 4'h0, 32'h0);
    end
  endtask : rd_all
  task automatic fwd4(input logic io);
    for (int k = 0; k < 4; k++) begin
      fq.push_back(k == 1 || k == 2);
      @(posedge core_clk);
      fwd_req <= '{k < 2 ? lo - 64'h1 + 64'(k) : hi + 64'(k) - 64'h2, io, 1'b1};
    end
    @(posedge core_clk);
    fwd_req.valid <= 1'b0;
  endtask : fwd4
  task automatic end_sim();
    if (fail_count == 0 && n_checks > 0 && rq.size() == 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  always @(posedge core_clk) begin
    v = fwd_req.valid;
    #1;
    chk({32'h0, fwd_hit}, {32'h0, v === 1'b1 ? fq.pop_front() : 1'b0});
    if (cfg_rsp.hit !== 1'b0) chk(cfg_rsp, rq.size() ? rq.pop_front() : 33'h0);
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    fwd_req = '0;
    {pbl, pll, ibl, ill} = '0;
    r = $urandom(3);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    ev = '{32'h0, 32'h0, 32'h0, 32'hdc, 32'h0};
    rd_all();
    r = $urandom();
    {pbl, pll, ibl, ill} <= {r[11:0], r[23:12], r[3:0], r[7:4]};
    wd = '{r >> 1, (r >> 1) + 1, {17'h0, r[15:1]}, {{1'b0, r[15:1]} + 16'h1, 16'h0}, ~r, ~r};
    foreach (wd[i]) cfg_sw_model_inst.xfer(1'b1, wo[i], wl[i], wd[i]);
    ev = '{wd[0], wd[1], {wd[3][31:16], wd[2][15:0]}, 32'hdc, 32'h0};
    rd_all();
    cfg_sw_model_inst.xfer(1'b0, 8'h38, 4'h0, 32'h0);
    lo = {wd[0], r[11:0], 20'h0};
    hi = {wd[1], r[23:12], 20'hfffff};
    fwd4(1'b0);
    lo = {32'h0, wd[2][15:0], r[3:0], 12'h0};
    hi = {32'h0, wd[3][31:16], r[7:4], 12'hfff};
    fwd4(1'b1);
    repeat (3) @(posedge core_clk);
    end_sim();
  end
endmodule : testbench
